// ### src/alu_dec_params.svh
// Constants for the compressed ALU group decoder
`ifndef ALU_DEC_PARAMS_SVH
`define ALU_DEC_PARAMS_SVH

// Opcode prefixes that select each group
`define TOP_SHIFT 3'h0
`define TOP_IMM 3'h1
`define ADDSUB_SEL 2'h3
`define ALU_PREFIX 6'h10

// Shift amount meaning a full word
`define SHIFT_FULL 8'h20

// Cycles per instruction class
`define CYC_SINGLE 3'h1
`define CYC_REG_SHIFT 3'h2
`define CYC_MUL 3'h4

// Reset value of the control state
`define CTL_RST '0

`endif

// ### src/alu_dec_pkg.sv
// Types shared by the compressed ALU group decoder
package alu_dec_pkg;

    // Condition flags
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } flags_t;

    // Register write-back
    typedef struct packed {
        logic        en;
        logic [2:0]  addr;
        logic [31:0] data;
    } wb_t;

    typedef enum logic [1:0] {sh_lsl = 2'h0, sh_lsr = 2'h1, sh_asr = 2'h2, sh_ror = 2'h3} shift_t;
    typedef enum logic [1:0] {im_mov = 2'h0, im_cmp = 2'h1, im_add = 2'h2, im_sub = 2'h3} imm_op_t;
    typedef enum logic [3:0] {
        op_and = 4'h0, op_eor = 4'h1, op_lsl = 4'h2, op_lsr = 4'h3,
        op_asr = 4'h4, op_adc = 4'h5, op_sbc = 4'h6, op_ror = 4'h7,
        op_tst = 4'h8, op_neg = 4'h9, op_cmp = 4'ha, op_cmn = 4'hb,
        op_orr = 4'hc, op_mul = 4'hd, op_bic = 4'he, op_mvn = 4'hf
    } alu_op_t;
    typedef enum logic [2:0] {fmt_shift, fmt_addsub, fmt_imm, fmt_alu, fmt_other} fmt_t;
    typedef enum logic {st_idle, st_exec} state_t;

    // Result of one instruction
    typedef struct packed {
        wb_t        wb;
        flags_t     f;
        logic       fwe;
        logic [2:0] cyc;
    } exe_t;

    // All module state
    typedef struct packed {
        state_t     st;
        logic [2:0] cnt;
        logic       done;
        wb_t        wb;
        flags_t     flg;
        logic       fwe;
        logic       unsup;
    } ctl_t;

endpackage

// ### src/compact_alu_format_decoder.sv
// Decoder and executor for the four compressed low-register ALU groups
//
// Overview of operation
// - Shift group code 00: shift source left by 5-bit immediate into destination.
// - Shift group code 01: logical right shift, zero fill, into destination.
// - Shift group code 10: arithmetic right shift, sign kept, into destination.
// - Every instruction of the four groups updates the condition flags.
// - Add/sub op 0, imm 0: destination gets sum of two low registers.
// - Add/sub op 0, imm 1: destination gets source plus 3-bit immediate.
// - Add/sub op 1, imm 0: destination gets source minus second register.
// - Add/sub op 1, imm 1: destination gets source minus 3-bit immediate.
// - Byte group code 00: load zero-extended byte into destination.
// - Byte group code 01: compare register with byte, flags only.
// - Byte group code 10: add byte to register, write back.
// - Byte group code 11: subtract byte from register, write back.
// - ALU codes 0000, 0001, 1100: AND, XOR, OR of destination and source.
// - ALU codes 1110, 1111, 1101: bit clear, inverted source, product.
// - ALU code 0101: destination plus source plus carry.
// - ALU code 0110: destination minus source minus inverted carry.
// - ALU codes 0010, 0011, 0100, 0111: shifts and rotate by source amount.
// - ALU code 1000: AND for flags only, no write.
// - ALU code 1010: destination minus source for flags only.
// - ALU code 1011: destination plus source for flags only.
// - ALU code 1001: destination gets zero minus source.
// - Each instruction takes the cycles of its full-width equivalent.
// - Three-bit register fields address general registers zero to seven.
`timescale 1ns/1ns
`include "alu_dec_params.svh"

module compact_alu_format_decoder
    import alu_dec_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Instruction from fetch
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr,
    output logic             instr_ready,
    // Register file read ports
    output logic [2:0]       rd_addr_a,
    output logic [2:0]       rd_addr_b,
    input  wire logic [31:0] rd_data_a,
    input  wire logic [31:0] rd_data_b,
    // Register file write port
    output logic             wr_en,
    output logic [2:0]       wr_addr,
    output logic [31:0]      wr_data,
    // Condition flags
    input  wire flags_t      status_flags_register,
    output logic             flags_we,
    output flags_t           flags_out,
    // Unknown encoding
    output logic             unsupported
);

    // ************************************************
    // Helper functions
    // ************************************************

    // Group of an instruction
    function automatic fmt_t fmt_of(input logic [15:0] ins);
        if (ins[15:13] == `TOP_SHIFT)
            return (ins[12:11] == `ADDSUB_SEL) ? fmt_addsub : fmt_shift;
        if (ins[15:13] == `TOP_IMM)
            return fmt_imm;
        if (ins[15:10] == `ALU_PREFIX)
            return fmt_alu;
        return fmt_other;
    endfunction

    // Adder: {carry, overflow, sum}
    function automatic logic [33:0] adder(input logic [31:0] a, input logic [31:0] b, input logic cin);
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, b} + {32'h0, cin};
        return {s[32], (a[31] == b[31]) && (s[31] != a[31]), s[31:0]};
    endfunction

    // Barrel shifter: {carry, value}
    function automatic logic [32:0] shifter(input logic [31:0] v, input logic [7:0] amt,
                                            input shift_t k, input logic cin);
        logic [32:0] r;
        logic [32:0] t;
        logic [63:0] w;
        logic [4:0]  n;
        n = amt[4:0];
        r = {cin, v};
        t = '0;
        w = '0;
        if (amt != 8'h0)
        begin
            case (k)
                sh_lsl:
                begin
                    t = {1'b0, v} << n;
                    r = (amt < `SHIFT_FULL) ? t : (amt == `SHIFT_FULL) ? {v[0], 32'h0} : '0;
                end
                sh_lsr:
                begin
                    t = {v, 1'b0} >> n;
                    r = (amt < `SHIFT_FULL) ? {t[0], t[32:1]} : (amt == `SHIFT_FULL) ? {v[31], 32'h0} : '0;
                end
                sh_asr:
                begin
                    t = 33'($signed({v, 1'b0}) >>> n);
                    r = (amt < `SHIFT_FULL) ? {t[0], t[32:1]} : {v[31], {32{v[31]}}};
                end
                default:
                begin
                    w = {v, v} >> n;
                    r = {w[31], w[31:0]};
                end
            endcase
        end
        return r;
    endfunction

    // Execute one instruction of the four groups
    function automatic exe_t exec(input fmt_t fm, input logic [15:0] ins, input logic [31:0] a,
                                  input logic [31:0] b, input flags_t f);
        exe_t        e;
        logic [33:0] ad;
        logic [32:0] sh;
        logic [31:0] res;
        logic [31:0] opnd;
        logic [31:0] byte_imm;
        logic [4:0]  shift_amount_imm;
        logic        arith;
        logic        shf;
        e = '{wb: '{en: 1'b1, addr: ins[2:0], data: 32'h0}, f: f, fwe: 1'b1, cyc: `CYC_SINGLE};
        ad = '0;
        sh = '0;
        res = '0;
        arith = 1'b0;
        shf = 1'b0;
        byte_imm = {24'h0, ins[7:0]};
        shift_amount_imm = ins[10:6];
        opnd = ins[10] ? {29'h0, ins[8:6]} : b;
        case (fm)
            fmt_shift:
            begin
                // Zero amount on right shifts means a full word
                sh = shifter(a, (ins[12:11] != sh_lsl && shift_amount_imm == 5'h0) ? `SHIFT_FULL
                             : {3'h0, shift_amount_imm}, shift_t'(ins[12:11]), f.c);
                shf = 1'b1;
            end
            fmt_addsub:
            begin
                ad = ins[9] ? adder(a, ~opnd, 1'b1) : adder(a, opnd, 1'b0);
                arith = 1'b1;
            end
            fmt_imm:
            begin
                e.wb.addr = ins[10:8];
                arith = 1'b1;
                case (imm_op_t'(ins[12:11]))
                    im_mov:
                    begin
                        arith = 1'b0;
                        res = byte_imm;
                    end
                    im_cmp:
                    begin
                        ad = adder(a, ~byte_imm, 1'b1);
                        e.wb.en = 1'b0;
                    end
                    im_add: ad = adder(a, byte_imm, 1'b0);
                    default: ad = adder(a, ~byte_imm, 1'b1);
                endcase
            end
            fmt_alu:
            begin
                case (alu_op_t'(ins[9:6]))
                    op_and: res = a & b;
                    op_eor: res = a ^ b;
                    op_orr: res = a | b;
                    op_bic: res = a & ~b;
                    op_mvn: res = ~b;
                    op_mul:
                    begin
                        res = a * b;
                        e.cyc = `CYC_MUL;
                    end
                    op_adc:
                    begin
                        ad = adder(a, b, f.c);
                        arith = 1'b1;
                    end
                    op_sbc:
                    begin
                        ad = adder(a, ~b, f.c);
                        arith = 1'b1;
                    end
                    op_lsl, op_lsr, op_asr, op_ror:
                    begin
                        sh = shifter(a, b[7:0], (ins[9:6] == op_lsl) ? sh_lsl : (ins[9:6] == op_lsr) ? sh_lsr
                                     : (ins[9:6] == op_asr) ? sh_asr : sh_ror, f.c);
                        shf = 1'b1;
                        e.cyc = `CYC_REG_SHIFT;
                    end
                    op_tst:
                    begin
                        res = a & b;
                        e.wb.en = 1'b0;
                    end
                    op_neg:
                    begin
                        ad = adder(32'h0, ~b, 1'b1);
                        arith = 1'b1;
                    end
                    op_cmp:
                    begin
                        ad = adder(a, ~b, 1'b1);
                        arith = 1'b1;
                        e.wb.en = 1'b0;
                    end
                    default:
                    begin
                        ad = adder(a, b, 1'b0);
                        arith = 1'b1;
                        e.wb.en = 1'b0;
                    end
                endcase
            end
            default:
            begin
                e.wb.en = 1'b0;
                e.fwe = 1'b0;
            end
        endcase
        if (arith)
            res = ad[31:0];
        if (shf)
            res = sh[31:0];
        // Flags from the result; logical ops keep C and V
        e.wb.data = res;
        e.f.n = res[31];
        e.f.z = (res == 32'h0);
        if (arith)
        begin
            e.f.c = ad[33];
            e.f.v = ad[32];
        end
        if (shf)
            e.f.c = sh[32];
        return e;
    endfunction

    // ************************************************
    // Decode and operand fetch
    // ************************************************

    ctl_t        s;
    ctl_t        next_s;
    fmt_t        fmt;
    logic [31:0] op_a;
    logic [31:0] op_b;
    flags_t      cur_flags;
    logic        take;

    // Read port selection, results forwarded from the write port
    assign fmt = fmt_of(instr);
    assign rd_addr_a = (fmt == fmt_imm) ? instr[10:8] : (fmt == fmt_alu) ? instr[2:0] : instr[5:3];
    assign rd_addr_b = (fmt == fmt_alu) ? instr[5:3] : instr[8:6];
    assign op_a = (wr_en && wr_addr == rd_addr_a) ? wr_data : rd_data_a;
    assign op_b = (wr_en && wr_addr == rd_addr_b) ? wr_data : rd_data_b;
    assign cur_flags = flags_we ? flags_out : status_flags_register;
    assign take = instr_valid && instr_ready;

    // ************************************************
    // Control state
    // ************************************************

    // Next state
    always_comb
    begin
        exe_t e;
        e = '0;
        next_s = s;
        next_s.done = 1'b0;
        case (s.st)
            st_idle:
            begin
                if (instr_valid)
                begin
                    e = exec(fmt, instr, op_a, op_b, cur_flags);
                    next_s.wb = e.wb;
                    next_s.flg = e.f;
                    next_s.fwe = e.fwe;
                    next_s.unsup = (fmt == fmt_other);
                    if (e.cyc == `CYC_SINGLE)
                        next_s.done = 1'b1;
                    else
                    begin
                        next_s.st = st_exec;
                        next_s.cnt = 3'(e.cyc - 3'h2);
                    end
                end
            end
            st_exec:
            begin
                if (s.cnt == 3'h0)
                begin
                    next_s.done = 1'b1;
                    next_s.st = st_idle;
                end
                else
                    next_s.cnt = 3'(s.cnt - 3'h1);
            end
            default: next_s = `CTL_RST;
        endcase
    end

    // State register
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            s <= `CTL_RST;
        else
            s <= next_s;
    end

    // Outputs
    assign instr_ready = (s.st == st_idle);
    assign wr_en = s.done & s.wb.en;
    assign wr_addr = s.wb.addr;
    assign wr_data = s.wb.data;
    assign flags_we = s.done & s.fwe;
    assign flags_out = s.flg;
    assign unsupported = s.done & s.unsup;

    // ************************************************
    // Assertions
    // ************************************************

    chk_lsl_imm_result: assert property (@(posedge mclk) disable iff (reset)
        take && fmt == fmt_shift && instr[12:11] == sh_lsl
        |=> wr_en && wr_data == ($past(op_a) << $past(instr[10:6]))) else $error("shift left result wrong");
    chk_lsr_imm_result: assert property (@(posedge mclk) disable iff (reset)
        take && fmt == fmt_shift && instr[12:11] == sh_lsr && instr[10:6] != 5'h0
        |=> wr_data == ($past(op_a) >> $past(instr[10:6]))) else $error("logical right result wrong");
    chk_flag_update: assert property (@(posedge mclk) disable iff (reset)
        take && fmt != fmt_other |-> ##[1:4] flags_we) else $error("flags not updated");
    chk_add_reg_sum: assert property (@(posedge mclk) disable iff (reset)
        take && fmt == fmt_addsub && instr[10:9] == 2'h0
        |=> wr_en && wr_data == 32'($past(op_a) + $past(op_b))) else $error("register add wrong");
    chk_mov_imm_load: assert property (@(posedge mclk) disable iff (reset)
        take && fmt == fmt_imm && instr[12:11] == im_mov
        |=> wr_en && wr_addr == $past(instr[10:8]) && wr_data == {24'h0, $past(instr[7:0])})
        else $error("byte load wrong");
    chk_cmp_imm_nowrite: assert property (@(posedge mclk) disable iff (reset)
        take && fmt == fmt_imm && instr[12:11] == im_cmp |=> !wr_en && flags_we) else $error("compare wrote");
    chk_tst_nowrite: assert property (@(posedge mclk) disable iff (reset)
        take && fmt == fmt_alu && instr[9:6] == op_tst |=> !wr_en && flags_we) else $error("test wrote");
    chk_neg_result: assert property (@(posedge mclk) disable iff (reset)
        take && fmt == fmt_alu && instr[9:6] == op_neg
        |=> wr_en && wr_data == 32'(32'h0 - $past(op_b))) else $error("negate wrong");
    chk_regshift_time: assert property (@(posedge mclk) disable iff (reset)
        take && fmt == fmt_alu && instr[9:6] == op_lsl
        |=> !wr_en && !instr_ready ##1 wr_en && instr_ready) else $error("shift timing wrong");
    chk_mul_time: assert property (@(posedge mclk) disable iff (reset)
        take && fmt == fmt_alu && instr[9:6] == op_mul
        |=> !wr_en [*3] ##1 wr_en) else $error("multiply timing wrong");

endmodule

// ### test/reg_file_model.sv
// Register file and flag store behind the decoder
`timescale 1ns/1ns

module reg_file_model
    import alu_dec_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Read ports
    input  wire logic [2:0]  rd_addr_a,
    input  wire logic [2:0]  rd_addr_b,
    output logic [31:0]      rd_data_a,
    output logic [31:0]      rd_data_b,
    // Write port and flags
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        flags_we,
    input  wire flags_t      flags_in,
    output flags_t           status_flags_register,
    // Bench control: late writes and preload
    input  wire logic        slow,
    input  wire logic        ld_en,
    input  wire logic [2:0]  ld_addr,
    input  wire logic [31:0] ld_data
);
    logic [31:0] regs [8];
    wb_t         pend = '0;

    // Eight low registers, read at once, a late write bypassed to the reads
    assign rd_data_a = (pend.en && pend.addr == rd_addr_a) ? pend.data : regs[rd_addr_a];
    assign rd_data_b = (pend.en && pend.addr == rd_addr_b) ? pend.data : regs[rd_addr_b];

    // Writes land at once, or a cycle late through a write buffer
    always @(posedge mclk)
    begin
        pend.en <= 1'b0;
        if (ld_en) regs[ld_addr] <= ld_data;
        if (pend.en) regs[pend.addr] <= pend.data;
        if (wr_en && slow) pend <= '{1'b1, wr_addr, wr_data};
        else if (wr_en) regs[wr_addr] <= wr_data;
    end

    // Flags take the decoder's update
    always @(posedge mclk or posedge reset)
    begin
        if (reset) status_flags_register <= '0;
        else if (flags_we) status_flags_register <= flags_in;
    end
endmodule

// ### test/compact_alu_format_decoder_tb.sv
// Self-checking bench for the compressed ALU group decoder
`timescale 1ns/1ns

module compact_alu_format_decoder_tb
    import alu_dec_pkg::*;
;
    logic        mclk;
    logic        reset = 1'b1;
    logic        instr_valid = 1'b0;
    logic [15:0] instr = '0;
    logic        instr_ready, wr_en, flags_we, unsupported, exp_unsup;
    logic [2:0]  rd_addr_a, rd_addr_b, wr_addr;
    logic [31:0] rd_data_a, rd_data_b, wr_data;
    flags_t      status_flags_register, flags_out, sf = '0;
    logic        slow = 1'b0;
    logic        ld_en = 1'b0;
    logic [2:0]  ld_addr = '0;
    logic [31:0] ld_data = '0;
    logic [31:0] sr [8];
    int          n_errors = 0;
    int          n_checks = 0;
    integer      seed = 32'h73f384ed;
    localparam logic [31:0] pre [8] = '{32'h80000001, 32'h0, 32'h20, 32'h21, 32'hffffffff,
                                        32'h7fffffff, 32'h1, 32'h12345678};
    localparam logic [15:0] corner [20] = '{16'h0807, 16'h0007, 16'h1027, 16'h3401, 16'h4166,
        16'h4095, 16'h40dc, 16'h4110, 16'h41d5, 16'h41cc, 16'h41ac, 16'h424b, 16'h4365,
        16'h4285, 16'h2e01, 16'h22ff, 16'h1fcf, 16'h4700, 16'he000, 16'hb500};
    localparam int lim [4] = '{3, 4, 4, 16};

    compact_alu_format_decoder i_compact_alu_format_decoder (.mclk(mclk), .reset(reset),
        .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .rd_addr_a(rd_addr_a),
        .rd_addr_b(rd_addr_b), .rd_data_a(rd_data_a), .rd_data_b(rd_data_b), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .status_flags_register(status_flags_register),
        .flags_we(flags_we), .flags_out(flags_out), .unsupported(unsupported));

    reg_file_model i_reg_file_model (.mclk(mclk), .reset(reset), .rd_addr_a(rd_addr_a),
        .rd_addr_b(rd_addr_b), .rd_data_a(rd_data_a), .rd_data_b(rd_data_b), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .flags_we(flags_we), .flags_in(flags_out),
        .status_flags_register(status_flags_register), .slow(slow), .ld_en(ld_en),
        .ld_addr(ld_addr), .ld_data(ld_data));

    // ****************
    // Expected values
    // ****************

    // Shift returning carry out and result
    function automatic logic [32:0] shf(input logic [31:0] a, input logic [7:0] n,
                                        input logic [1:0] k, input logic cin);
        logic [32:0] x;
        logic [31:0] r;
        if (n == 8'h0) return {cin, a};
        r = (a >> n[4:0]) | (a << (6'h20 - {1'b0, n[4:0]}));
        x = {1'b0, a} << n;
        if (k == 2'h1) x = {a, 1'b0} >> n;
        if (k == 2'h2) x = $signed({a, 1'b0}) >>> n;
        if (k == 2'h0) return x;
        if (k == 2'h3) return {r[31], r};
        return {x[0], x[32:1]};
    endfunction

    // Outcome of one instruction from the shadow state
    function automatic exe_t predict(input logic [15:0] w);
        exe_t        e;
        logic [32:0] x;
        logic [31:0] a, b, r;
        logic        ar, sub;
        logic [7:0]  n;
        logic [3:0]  op;
        e = '0;
        e.f = sf;
        {e.fwe, e.cyc, e.wb.en, e.wb.addr} = {1'b1, 3'h1, 1'b1, w[2:0]};
        {a, b, r, ar, sub, exp_unsup, op} = {sr[w[5:3]], sr[w[8:6]], 32'h0, 3'h0, w[9:6]};
        if (w[15:11] == 5'h03)
        begin
            {ar, sub} = {1'b1, w[9]};
            if (w[10]) b = {29'h0, w[8:6]};
        end
        else if (w[15:13] == 3'h0)
        begin
            n = {3'h0, w[10:6]};
            if (n == 8'h0 && w[12:11] != 2'h0) n = 8'h20;
            {e.f.c, r} = shf(a, n, w[12:11], sf.c);
        end
        else if (w[15:13] == 3'h1)
        begin
            {e.wb.addr, a, b, r} = {w[10:8], sr[w[10:8]], 24'h0, w[7:0], 24'h0, w[7:0]};
            {ar, sub} = {w[12:11] != 2'h0, w[11]};
            e.wb.en = (w[12:11] != 2'h1);
        end
        else if (w[15:10] == 6'h10)
        begin
            {a, b} = {sr[w[2:0]], sr[w[5:3]]};
            case (op)
                4'h0, 4'h8: r = a & b;
                4'h1: r = a ^ b;
                4'hc: r = a | b;
                4'he: r = a & ~b;
                4'hf: r = ~b;
                4'hd: {r, e.cyc} = {a * b, 3'h4};
                4'h5, 4'hb: ar = 1'b1;
                4'h6, 4'ha: {ar, sub} = 2'h3;
                4'h9: {a, ar, sub} = {32'h0, 2'h3};
                default: {e.f.c, r, e.cyc} = {shf(a, b[7:0], (op == 4'h7) ? 2'h3 : 2'(op - 4'h2), sf.c), 3'h2};
            endcase
            e.wb.en = !(op inside {4'h8, 4'ha, 4'hb});
        end
        else {e.wb.en, e.fwe, exp_unsup} = 3'h1;
        if (ar)
        begin
            if (sub) b = ~b;
            x = {1'b0, a} + {1'b0, b} + {32'h0, (w[15:10] == 6'h10 && op inside {4'h5, 4'h6}) ? sf.c : sub};
            {e.f.c, r} = x;
            e.f.v = (a[31] == b[31]) && (r[31] != a[31]);
        end
        {e.f.n, e.f.z, e.wb.data} = {r[31], r == 32'h0, r};
        return e;
    endfunction

    // Random word of one group and operation
    function automatic logic [15:0] mk(input int g, input logic [3:0] op, input logic [15:0] r);
        if (g == 0) return {3'h0, op[1:0], r[10:0]};
        if (g == 1) return {5'h03, op[1:0], r[8:0]};
        if (g == 2) return {3'h1, op[1:0], r[10:0]};
        if (g == 3) return {6'h10, op, r[5:0]};
        return r;
    endfunction

    // ****************
    // Bench tasks
    // ****************

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task load(input logic [2:0] a, input logic [31:0] d);
        @(posedge mclk);
        ld_en <= 1'b1;
        ld_addr <= a;
        ld_data <= d;
        sr[a] = d;
        @(posedge mclk);
        ld_en <= 1'b0;
    endtask

    // Issue one word, time the answer, compare it
    task run(input logic [15:0] w);
        exe_t e;
        int   n;
        e = predict(w);
        n = 0;
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr <= w;
        @(posedge mclk);
        instr_valid <= 1'b0;
        // Pulses stand for one cycle only, e.cyc cycles after the taking edge
        #1;
        n = 1;
        while ({wr_en, flags_we, unsupported} === 3'h0 && n < 8)
        begin
            if (n < e.cyc) check(32'(instr_ready), 32'h0);
            @(posedge mclk);
            #1;
            n++;
        end
        check(32'(n), 32'(e.cyc));
        check(32'(unsupported), 32'(exp_unsup));
        check(32'(wr_en), 32'(e.wb.en));
        check(32'(flags_we), 32'(e.fwe));
        if (e.wb.en) check(32'(wr_addr), 32'(e.wb.addr));
        if (e.wb.en) check(wr_data, e.wb.data);
        if (e.fwe) check(32'(flags_out), 32'(e.f));
        if (e.wb.en) sr[e.wb.addr] = e.wb.data;
        if (e.fwe) sf = e.f;
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ****************
    // Clock, sequence, watchdog
    // ****************

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    initial
    begin
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1;
        check(32'({instr_ready, wr_en, flags_we, unsupported}), 32'h8);
        for (int i = 0; i < 8; i++) load(3'(i), pre[i]);
        foreach (corner[i]) run(corner[i]);
        $display("test corner cases done");
        for (int g = 0; g < 4; g++)
            for (int op = 0; op < lim[g]; op++) run(mk(g, 4'(op), 16'($random(seed))));
        $display("test every code done");
        for (int i = 0; i < 8; i++) load(3'(i), $random(seed));
        slow <= 1'b1;
        repeat (300) run(mk($unsigned($random(seed)) % 5, 4'($random(seed)), 16'($random(seed))));
        $display("test random stream done");
        print_verdict;
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        print_verdict;
    end
endmodule
